// ---- common/fpo_regs.vh ----
// Purpose: constants for the flash protect and overlay register set
// Assumes: byte-wide cpu register port, 24-bit cpu addresses
// Notes: included by the core files and the register test
`ifndef FPO_REGS_VH
`define FPO_REGS_VH
// ********************
// addresses
// ********************
`define FPO_ADDR_MODE_CTRL 24'hFFFFC8
`define FPO_ADDR_ERR_STATUS 24'hFFFFC9
`define FPO_ADDR_EBS_LOW 24'hFFFFCA
`define FPO_ADDR_EBS_HIGH 24'hFFFFCB
`define FPO_ADDR_WIN_CTRL 24'hFFFF42
`define FPO_ADDR_OVL_CTRL 24'hFFFEDB
// ********************
// fields and resets
// ********************
`define FPO_ERR_FLAG_BIT 7
`define FPO_SWE_BIT 6
`define FPO_WIN_EN_BIT 3
`define FPO_OVL_SEL_BIT 3
`define FPO_EBS_HIGH_MASK 8'h0F
`define FPO_MODE_CTRL_RST 8'h80
`define FPO_REG_RST 8'h00
`define FPO_ACCESS_STATES 2
// ********************
// memory map
// ********************
`define FPO_OVL_RAM_BASE 24'hFFDC00
`define FPO_OVL_RAM_LAST 24'hFFEBFF
`define FPO_BLK8_BASE 24'h008000
`define FPO_FLASH_LAST 24'h03FFFF
`endif

// ---- core/fpo_block_decode.v ----
// Purpose: maps a flash address to its erase block number
// Assumes: 24-bit address, twelve blocks
// Notes: out of range addresses give no valid block
`timescale 1ns/1ps
`default_nettype none
`include "fpo_regs.vh"
module fpo_block_decode (
  input wire [23:0] addr,
  output reg [3:0] block,
  output reg valid
);
  // ********************
  // block map
  // ********************
  always @* begin
    valid = (addr <= `FPO_FLASH_LAST);
    if (addr < `FPO_BLK8_BASE) begin
      block = {1'b0, addr[14:12]};
    end else if (addr[23:16] == 8'h00) begin
      block = 4'h8;
    end else begin
      block = 4'h8 + {2'b00, addr[17:16]};
    end
  end
endmodule // fpo_block_decode
`default_nettype wire

// ---- core/fpo_regs_top.v ----
// Purpose: flash error, erase select, register window and ram overlay control
// Assumes: byte cpu port with access strobe, one clock, mode levels from pins
// Notes: the mode bits below software write enable are outside this block
`timescale 1ns/1ps
`default_nettype none
`include "fpo_regs.vh"
module fpo_regs_top #(
  parameter FLASH_VARIANT = 1,
  parameter [7:0] MASK_ROM_READ = 8'h00
) (
  input wire clk,
  input wire rst_n,
  input wire hw_standby,
  input wire sw_standby,
  input wire flash_enabled,
  input wire user_mode,
  input wire acc_req,
  input wire acc_wr,
  input wire [23:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire op_fail,
  input wire [23:0] op_addr,
  input wire [23:0] cpu_addr,
  output reg [7:0] acc_rdata,
  output reg acc_ack,
  output reg acc_hit,
  output reg erase_allowed,
  output reg program_allowed,
  output reg [11:0] erase_enable,
  output reg overlay_hit,
  output reg [23:0] overlay_ram_addr,
  output reg error_protect
);
  // ********************
  // pin synchronisers
  // ********************
  reg [1:0] hw_sb_s_q;
  reg [1:0] sw_sb_s_q;
  reg [1:0] fl_en_s_q;
  reg [1:0] user_s_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_sb_s_q <= 2'b00;
      sw_sb_s_q <= 2'b00;
      fl_en_s_q <= 2'b00;
      user_s_q <= 2'b00;
    end else begin
      hw_sb_s_q <= {hw_sb_s_q[0], hw_standby};
      sw_sb_s_q <= {sw_sb_s_q[0], sw_standby};
      fl_en_s_q <= {fl_en_s_q[0], flash_enabled};
      user_s_q <= {user_s_q[0], user_mode};
    end
  end
  wire hw_sb = hw_sb_s_q[1];
  wire sw_sb = sw_sb_s_q[1];
  wire fl_en = fl_en_s_q[1];
  wire user_ok = user_s_q[1];

  // ********************
  // access sequencer
  // ********************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg wr_q;
  reg [23:0] addr_q;
  reg [7:0] wdata_q;
  wire do_wr = (st_q == ST_DONE) && wr_q;
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        cnt_d = 2'd1;
        if (acc_req) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_q >= (`FPO_ACCESS_STATES - 1)) begin
          st_d = ST_DONE;
        end else begin
          cnt_d = cnt_q + 2'd1;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 2'd0;
      wr_q <= 1'b0;
      addr_q <= 24'h000000;
      wdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (st_q == ST_IDLE && acc_req) begin
        wr_q <= acc_wr;
        addr_q <= acc_addr;
        wdata_q <= acc_wdata;
      end
    end
  end

  // ********************
  // registers
  // ********************
  reg [7:0] mode_q;
  reg err_q;
  reg [7:0] ebs_lo_q;
  reg [3:0] ebs_hi_q;
  reg win_en_q;
  reg [3:0] ovl_q;
  wire software_write_enable = mode_q[`FPO_SWE_BIT];
  // the window gates only the four flash registers; overlay stays reachable
  wire fl_sel = fl_en && win_en_q;
  wire sel_mode = fl_sel && (addr_q == `FPO_ADDR_MODE_CTRL);
  wire sel_err = fl_sel && (addr_q == `FPO_ADDR_ERR_STATUS);
  wire sel_lo = fl_sel && (addr_q == `FPO_ADDR_EBS_LOW);
  wire sel_hi = fl_sel && (addr_q == `FPO_ADDR_EBS_HIGH);
  wire sel_win = (addr_q == `FPO_ADDR_WIN_CTRL);
  wire sel_ovl = (addr_q == `FPO_ADDR_OVL_CTRL);
  wire fail_blk = op_fail && software_write_enable;
  reg [7:0] lo_d;
  reg [3:0] hi_d;
  always @* begin
    lo_d = ebs_lo_q;
    hi_d = ebs_hi_q;
    if (do_wr && sel_lo) begin
      lo_d = acc_wdata_byte(wdata_q);
    end
    if (do_wr && sel_hi) begin
      hi_d = wdata_q[3:0];
    end
  end
  function [7:0] acc_wdata_byte;
    input [7:0] v;
    begin
      acc_wdata_byte = v;
    end
  endfunction
  // count set bits across both selects
  reg [3:0] ones;
  integer i;
  always @* begin
    ones = 4'd0;
    for (i = 0; i < 12; i = i + 1) begin
      ones = ones + {3'b000, (i < 8) ? lo_d[i] : hi_d[i - 8]};
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `FPO_MODE_CTRL_RST;
      err_q <= 1'b0;
      ebs_lo_q <= `FPO_REG_RST;
      ebs_hi_q <= 4'h0;
      win_en_q <= 1'b0;
      ovl_q <= 4'h0;
    end else if (hw_sb) begin
      mode_q <= `FPO_MODE_CTRL_RST;
      err_q <= 1'b0;
      ebs_lo_q <= `FPO_REG_RST;
      ebs_hi_q <= 4'h0;
      win_en_q <= 1'b0;
      ovl_q <= 4'h0;
    end else begin
      // software write enable, only bit this block keeps of mode control
      if (sw_sb) begin
        mode_q <= `FPO_MODE_CTRL_RST;
      end else if (do_wr && sel_mode) begin
        mode_q <= {1'b1, wdata_q[`FPO_SWE_BIT], 6'h00};
      end
      // set-only flag; no register write can clear it, only software or hardware standby and reset
      if (fail_blk) begin
        err_q <= 1'b1;
      end else if (sw_sb) begin
        err_q <= 1'b0;
      end
      if (sw_sb || !software_write_enable || ones > 4'd1) begin
        ebs_lo_q <= `FPO_REG_RST;
        ebs_hi_q <= 4'h0;
      end else begin
        ebs_lo_q <= lo_d;
        ebs_hi_q <= hi_d;
      end
      if (do_wr && sel_win && FLASH_VARIANT != 0) begin
        win_en_q <= wdata_q[`FPO_WIN_EN_BIT];
      end
      // overlay survives software standby
      if (do_wr && sel_ovl) begin
        ovl_q <= wdata_q[3:0];
      end
    end
  end

  // ********************
  // read data and outputs
  // ********************
  reg [7:0] rd_d;
  reg hit_d;
  always @* begin
    rd_d = 8'h00;
    hit_d = 1'b1;
    if (sel_mode) begin
      rd_d = mode_q;
    end else if (sel_err) begin
      rd_d = {err_q, 7'h00};
    end else if (sel_lo) begin
      rd_d = ebs_lo_q;
    end else if (sel_hi) begin
      rd_d = {4'h0, ebs_hi_q};
    end else if (sel_win) begin
      rd_d = (FLASH_VARIANT != 0) ? {4'h0, win_en_q, 3'b000} : MASK_ROM_READ;
    end else if (sel_ovl) begin
      rd_d = {4'h0, ovl_q};
    end else if (!fl_en && addr_q >= `FPO_ADDR_MODE_CTRL &&
                 addr_q <= `FPO_ADDR_EBS_HIGH && win_en_q) begin
      rd_d = 8'h00;
    end else begin
      hit_d = 1'b0;
    end
  end
  wire prot = err_q || ovl_q[`FPO_OVL_SEL_BIT];
  wire [3:0] blk;
  wire blk_ok;
  fpo_block_decode u_dec (
    .addr(op_addr),
    .block(blk),
    .valid(blk_ok)
  );
  wire [11:0] ebs_all = {ebs_hi_q, ebs_lo_q};
  wire in_ovl_ram = (cpu_addr >= `FPO_OVL_RAM_BASE) && (cpu_addr <= `FPO_OVL_RAM_LAST);
  wire in_ovl_blk = (cpu_addr[23:15] == 9'h000) && (cpu_addr[14:12] == ovl_q[2:0]);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata <= 8'h00;
      acc_ack <= 1'b0;
      acc_hit <= 1'b0;
      erase_allowed <= 1'b0;
      program_allowed <= 1'b0;
      erase_enable <= 12'h000;
      overlay_hit <= 1'b0;
      overlay_ram_addr <= 24'h000000;
      error_protect <= 1'b0;
    end else begin
      acc_ack <= (st_q == ST_DONE);
      acc_hit <= (st_q == ST_DONE) && hit_d;
      acc_rdata <= (st_q == ST_DONE && !wr_q) ? rd_d : 8'h00;
      erase_enable <= prot ? 12'h000 : ebs_all;
      erase_allowed <= !prot && software_write_enable && fl_en && blk_ok && ebs_all[blk];
      program_allowed <= !prot && software_write_enable && fl_en && blk_ok;
      // flash block n seen through overlay ram, ram itself stays plain
      overlay_hit <= ovl_q[`FPO_OVL_SEL_BIT] && in_ovl_blk;
      overlay_ram_addr <= `FPO_OVL_RAM_BASE + {12'h000, cpu_addr[11:0]};
      error_protect <= err_q;
    end
  end
  wire unused_ok = user_ok & in_ovl_ram;
endmodule // fpo_regs_top
`default_nettype wire

// ---- verification/fpo_regs_asserts.sv ----
// Purpose: port timing checks for the register set
// Assumes: one clock, async low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module fpo_regs_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic flash_enabled,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_ack,
  input wire logic acc_hit,
  input wire logic erase_allowed,
  input wire logic program_allowed,
  input wire logic [11:0] erase_enable,
  input wire logic overlay_hit,
  input wire logic [23:0] overlay_ram_addr,
  input wire logic error_protect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_one_cycle_a: assert property (acc_ack |=> !acc_ack)
    else $error("ack held longer than one cycle");
  rdata_idle_a: assert property (!acc_ack |-> acc_rdata == 8'h00)
    else $error("read data outside ack");
  hit_with_ack_a: assert property (acc_hit |-> acc_ack)
    else $error("hit without ack");
  err_hold_a: assert property ((!hw_standby && !sw_standby)[*4] ##0 error_protect |=> error_protect)
    else $error("error flag dropped without standby");
  err_gates_a: assert property (error_protect[*2] |-> erase_enable == 12'h000 && !erase_allowed && !program_allowed)
    else $error("operation allowed under error protection");
  onehot_sel_a: assert property ($onehot0(erase_enable))
    else $error("more than one erase block enabled");
  erase_sel_a: assert property (erase_allowed |-> erase_enable != 12'h000)
    else $error("erase allowed with no block selected");
  ovl_protect_a: assert property (overlay_hit[*2] |-> !program_allowed && !erase_allowed)
    else $error("operation allowed while overlay on");
  ovl_range_a: assert property (overlay_hit |-> overlay_ram_addr >= 24'hFFDC00 && overlay_ram_addr <= 24'hFFEBFF)
    else $error("overlay address out of ram window");
  flash_off_a: assert property ((!flash_enabled)[*4] |-> !erase_allowed && !program_allowed)
    else $error("operation allowed with flash disabled");
endmodule // fpo_regs_asserts
bind fpo_regs_top fpo_regs_asserts chk_u (.clk(clk), .rst_n(rst_n), .hw_standby(hw_standby),
  .sw_standby(sw_standby), .flash_enabled(flash_enabled), .acc_rdata(acc_rdata),
  .acc_ack(acc_ack), .acc_hit(acc_hit), .erase_allowed(erase_allowed),
  .program_allowed(program_allowed), .erase_enable(erase_enable), .overlay_hit(overlay_hit),
  .overlay_ram_addr(overlay_ram_addr), .error_protect(error_protect));
`default_nettype wire

// ---- verification/fpo_regs_top_test.sv ----
// Purpose: directed register sequences for the register set
// Assumes: inputs driven 1 ns after the rising edge
// Notes: levels get three cycles to settle through the synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "fpo_regs.vh"
module fpo_regs_top_test;
  logic clk, rst_n, hw_standby, sw_standby, flash_enabled, acc_req, acc_wr, op_fail;
  logic [23:0] acc_addr, op_addr, cpu_addr, overlay_ram_addr;
  logic [7:0] acc_wdata, acc_rdata;
  logic acc_ack, acc_hit, erase_allowed, program_allowed, overlay_hit, error_protect;
  logic [11:0] erase_enable;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  // user_mode tied high: overlay writes only ever made in user mode
  fpo_regs_top dut_u (.clk(clk), .rst_n(rst_n), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .flash_enabled(flash_enabled), .user_mode(1'b1), .acc_req(acc_req), .acc_wr(acc_wr),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .op_fail(op_fail), .op_addr(op_addr),
    .cpu_addr(cpu_addr), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_hit(acc_hit),
    .erase_allowed(erase_allowed), .program_allowed(program_allowed),
    .erase_enable(erase_enable), .overlay_hit(overlay_hit),
    .overlay_ram_addr(overlay_ram_addr), .error_protect(error_protect));
  // ****
  // tasks
  // ****
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task acc(input logic w, input logic [23:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    #1 {acc_req, acc_wr, acc_addr, acc_wdata} = {1'b1, w, a, d};
    @(posedge clk);
    #1 acc_req = 1'b0;
    // ack stands one cycle, so poll each cycle with a bound
    for (k = 0; k < 8 && acc_ack !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("ack", 24'h1, {23'h0, acc_ack});
  endtask
  task wr(input logic [23:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task rd(input logic [23:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, {16'h0, e}, {16'h0, acc_rdata});
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict;
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    {clk, rst_n, hw_standby, sw_standby, acc_req, acc_wr, op_fail} = 7'h00;
    {flash_enabled, acc_addr, acc_wdata, op_addr, cpu_addr} = {1'b1, 80'h0};
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(`FPO_ADDR_MODE_CTRL, 8'h00, "hidden_mode");
    chk("hidden_hit", 24'h0, {23'h0, acc_hit});
    rd(`FPO_ADDR_WIN_CTRL, 8'h00, "win_rst");
    rd(`FPO_ADDR_OVL_CTRL, 8'h00, "ovl_rst");
    wr(`FPO_ADDR_WIN_CTRL, 8'hFF);
    rd(`FPO_ADDR_WIN_CTRL, 8'h08, "win_rsvd");
    rd(`FPO_ADDR_ERR_STATUS, 8'h00, "err_rst");
    wr(`FPO_ADDR_EBS_LOW, 8'h01);
    rd(`FPO_ADDR_EBS_LOW, 8'h00, "ebs_no_swe");
    wr(`FPO_ADDR_MODE_CTRL, 8'h40);
    wr(`FPO_ADDR_EBS_LOW, 8'h01);
    rd(`FPO_ADDR_EBS_LOW, 8'h01, "ebs_low");
    op_addr = 24'h000100;
    settle;
    chk("erase_blk0", 24'h1, {23'h0, erase_allowed});
    op_addr = 24'h001000;
    settle;
    chk("erase_blk1", 24'h0, {23'h0, erase_allowed});
    wr(`FPO_ADDR_EBS_HIGH, 8'hFF);
    rd(`FPO_ADDR_EBS_LOW, 8'h00, "multi_low");
    rd(`FPO_ADDR_EBS_HIGH, 8'h00, "multi_high");
    wr(`FPO_ADDR_EBS_HIGH, 8'hF8);
    rd(`FPO_ADDR_EBS_HIGH, 8'h08, "high_rsvd");
    op_addr = 24'h030000;
    settle;
    chk("erase_blk11", 24'h1, {23'h0, erase_allowed});
    chk("enable_blk11", 24'h800, {12'h0, erase_enable});
    wr(`FPO_ADDR_OVL_CTRL, 8'hFD);
    rd(`FPO_ADDR_OVL_CTRL, 8'h0D, "ovl_rsvd");
    cpu_addr = 24'h005123;
    settle;
    chk("ovl_hit", 24'h1, {23'h0, overlay_hit});
    chk("ovl_addr", 24'hFFDD23, overlay_ram_addr);
    chk("ovl_prog", 24'h0, {23'h0, program_allowed});
    wr(`FPO_ADDR_OVL_CTRL, 8'h05);
    settle;
    chk("ovl_off", 24'h0, {23'h0, overlay_hit});
    chk("prog_free", 24'h1, {23'h0, program_allowed});
    op_fail = 1'b1;
    @(posedge clk);
    #1 op_fail = 1'b0;
    settle;
    chk("err_flag", 24'h1, {23'h0, error_protect});
    chk("err_erase", 24'h0, {23'h0, erase_allowed});
    wr(`FPO_ADDR_ERR_STATUS, 8'h00);
    rd(`FPO_ADDR_ERR_STATUS, 8'h80, "err_ro");
    flash_enabled = 1'b0;
    settle;
    rd(`FPO_ADDR_MODE_CTRL, 8'h00, "dis_read");
    wr(`FPO_ADDR_MODE_CTRL, 8'h00);
    flash_enabled = 1'b1;
    settle;
    rd(`FPO_ADDR_MODE_CTRL, 8'hC0, "dis_write");
    sw_standby = 1'b1;
    settle;
    sw_standby = 1'b0;
    settle;
    rd(`FPO_ADDR_ERR_STATUS, 8'h00, "err_sw");
    rd(`FPO_ADDR_OVL_CTRL, 8'h05, "ovl_sw");
    rd(`FPO_ADDR_EBS_HIGH, 8'h00, "ebs_sw");
    rd(`FPO_ADDR_WIN_CTRL, 8'h08, "win_sw");
    hw_standby = 1'b1;
    settle;
    hw_standby = 1'b0;
    settle;
    rd(`FPO_ADDR_WIN_CTRL, 8'h00, "win_hw");
    rd(`FPO_ADDR_OVL_CTRL, 8'h00, "ovl_hw");
    print_verdict;
  end
endmodule // fpo_regs_top_test
`default_nettype wire
